// ---- rtl/ccr_regs.sv ----
// How it works
// R01: Control one resets to 0x1A.
// R02: Bit 7 disables light-load mode; register reset only.
// R03: Kick bit self-clears after watchdog restart or expiry.
// R04: Reverse boost beats charge enable.
// R05: Charge needs enable bit and pin low.
// R06: Minimum system field decodes 2.6V to 3.7V.
// R07: Current limit register resets to 0xB4.
// R08: Bit 7 selects 0.5A or 1.2A boost.
// R09: Switch bit 0 means high resistance below 700mA.
// R10: Fast-charge code maps through segmented table.
// R11: Pre/term register resets to 0xAA.
// R12: Pre-charge code maps through small table.
// R13: Termination code uses same small table.
// R14: Fields read back last written value.
`timescale 1ns/10ps
module ccr_regs (
  input  wire logic                        CLK_I,
  input  wire logic                        RST_N_I,
  input  wire ccr_pkg::ccr_reg_req_t       REQ_I,
  input  wire logic                        REG_RESET_CMD_I,
  input  wire logic                        WDOG_EXPIRED_I,
  input  wire logic                        WDOG_RESTARTED_I,
  input  wire logic                        CHARGE_ENABLE_PIN_N_I,
  input  wire logic [4:0]                  INPUT_CURRENT_LIMIT_I,
  output logic      [7:0]                  RD_DATA_O,
  output logic                             RD_VALID_O,
  output logic                             WATCHDOG_KICK_O,
  output logic                             LIGHT_LOAD_MODE_ENABLE_O,
  output logic                             REVERSE_BOOST_ACTIVE_O,
  output logic                             CHARGE_ACTIVE_O,
  output logic      [11:0]                 MIN_SYSTEM_MV_O,
  output logic                             MIN_BATTERY_SEL_O,
  output logic      [11:0]                 BOOST_CURRENT_LIMIT_MA_O,
  output logic                             INPUT_SWITCH_HIGH_RES_O,
  output ccr_pkg::ccr_currents_t           CURRENTS_O
);

  // Minimum system voltage table in mV, code 000 .. 111
  localparam logic [11:0] MIN_SYS_TABLE [8] = '{
    12'ha28, 12'haf0, 12'hbb8, 12'hc80, 12'hd48, 12'hdac, 12'he10, 12'he74};

  logic [7:0]  ctrl_one;
  logic [7:0]  cur_lim;
  logic [7:0]  pre_term;
  logic [7:0]  next_ctrl_one;
  logic [7:0]  next_cur_lim;
  logic [7:0]  next_pre_term;
  logic [7:0]  next_rd_data;
  logic        next_rd_valid;
  logic        next_light_load;
  logic        next_boost_act;
  logic        next_charge_act;
  logic [11:0] next_min_sys_mv;
  logic [11:0] next_boost_current_limit;
  logic        next_high_res;
  logic [11:0] in_lim_ma;

  // Per-register write strobes
  logic        wr_ctrl_one;
  logic        wr_cur_lim;
  logic        wr_pre_term;
  logic        kick_written;

  // Restore only the fields covered by a mask
  function automatic logic [7:0] restore(input logic [7:0] cur, input logic [7:0] dflt, input logic [7:0] mask);
    restore = (cur & ~mask) | (dflt & mask);
  endfunction

  // Offset decode shared by the three registers; other offsets write nothing
  assign wr_ctrl_one  = REQ_I.wr && (REQ_I.addr == ccr_pkg::ADDR_CTRL_ONE);    // R14
  assign wr_cur_lim   = REQ_I.wr && (REQ_I.addr == ccr_pkg::ADDR_CURRENT_LIM); // R14
  assign wr_pre_term  = REQ_I.wr && (REQ_I.addr == ccr_pkg::ADDR_PRE_TERM);    // R14

  // A kick written now outlives a restart seen in the same cycle
  assign kick_written = wr_ctrl_one && REQ_I.wdata[ccr_pkg::WDOG_KICK_BIT];

  // Control one: register reset beats watchdog expiry, which beats a host write
  always_comb begin
    next_ctrl_one = ctrl_one;
    // A host write lands first, the commands then override it
    if (wr_ctrl_one) begin
      next_ctrl_one = REQ_I.wdata; // R14
    end
    // Kick clears once the restart has been served
    if (WDOG_RESTARTED_I && !kick_written) begin
      next_ctrl_one[ccr_pkg::WDOG_KICK_BIT] = 1'b0; // R03
    end
    // Expiry starts from the written value, so unrestored bits keep a same-cycle write
    if (WDOG_EXPIRED_I) begin
      next_ctrl_one = restore(next_ctrl_one, ccr_pkg::RST_CTRL_ONE, ccr_pkg::WDOG_MASK_CTRL); // R02 R03 R04 R05
    end
    // Register reset restores every field, light-load and minimum system too
    if (REG_RESET_CMD_I) begin
      next_ctrl_one = ccr_pkg::RST_CTRL_ONE; // R01
    end
  end

  // Control one storage
  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      ctrl_one <= ccr_pkg::RST_CTRL_ONE; // R01
    end else begin
      ctrl_one <= next_ctrl_one;
    end
  end

  // Current limit: the input switch bit survives watchdog expiry
  always_comb begin
    next_cur_lim = cur_lim;
    if (wr_cur_lim) begin
      next_cur_lim = REQ_I.wdata; // R14
    end
    // Boost limit and fast-charge code fall back, the switch bit does not
    if (WDOG_EXPIRED_I) begin
      next_cur_lim = restore(next_cur_lim, ccr_pkg::RST_CURRENT_LIM, ccr_pkg::WDOG_MASK_CURLIM); // R08 R09
    end
    if (REG_RESET_CMD_I) begin
      next_cur_lim = ccr_pkg::RST_CURRENT_LIM; // R07
    end
  end

  // Current limit storage
  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      cur_lim <= ccr_pkg::RST_CURRENT_LIM; // R07
    end else begin
      cur_lim <= next_cur_lim;
    end
  end

  // Pre-charge and termination codes: both fields return on expiry
  always_comb begin
    next_pre_term = pre_term;
    if (wr_pre_term) begin
      next_pre_term = REQ_I.wdata; // R14
    end
    // Whole register is covered by the expiry mask
    if (WDOG_EXPIRED_I) begin
      next_pre_term = restore(next_pre_term, ccr_pkg::RST_PRE_TERM, ccr_pkg::WDOG_MASK_PRETERM); // R11
    end
    if (REG_RESET_CMD_I) begin
      next_pre_term = ccr_pkg::RST_PRE_TERM; // R11
    end
  end

  // Pre-charge and termination storage
  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      pre_term <= ccr_pkg::RST_PRE_TERM; // R11
    end else begin
      pre_term <= next_pre_term;
    end
  end

  // Read port: one-cycle answer, unmapped offsets read zero
  always_comb begin
    next_rd_valid = REQ_I.rd;
    next_rd_data  = '0;
    if (REQ_I.rd) begin
      unique case (REQ_I.addr)
        ccr_pkg::ADDR_CTRL_ONE:    next_rd_data = ctrl_one; // R14
        ccr_pkg::ADDR_CURRENT_LIM: next_rd_data = cur_lim;  // R14
        ccr_pkg::ADDR_PRE_TERM:    next_rd_data = pre_term; // R14
        default:                   next_rd_data = '0;
      endcase
    end
  end

  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      RD_DATA_O  <= '0;
      RD_VALID_O <= 1'b0;
    end else begin
      RD_DATA_O  <= next_rd_data;
      RD_VALID_O <= next_rd_valid;
    end
  end

  // Decoded controls toward the power stage, one cycle behind the registers
  assign in_lim_ma = 12'(ccr_pkg::IN_LIM_OFFSET_MA + ccr_pkg::IN_LIM_STEP_MA * {7'h00, INPUT_CURRENT_LIMIT_I});

  always_comb begin
    next_light_load = ~ctrl_one[ccr_pkg::LIGHT_LOAD_DIS_BIT];                                 // R02
    next_boost_act  = ctrl_one[ccr_pkg::REV_BOOST_BIT];                                        // R04
    // Boost has priority, so the two modes never overlap
    next_charge_act = ~ctrl_one[ccr_pkg::REV_BOOST_BIT] & ctrl_one[ccr_pkg::CHG_EN_BIT] &
                      ~CHARGE_ENABLE_PIN_N_I;                                                   // R04 R05
    next_min_sys_mv = MIN_SYS_TABLE[ctrl_one[ccr_pkg::MIN_SYS_MSB:ccr_pkg::MIN_SYS_LSB]];      // R06
    next_boost_current_limit  = cur_lim[ccr_pkg::BOOST_CURRENT_LIMIT_BIT] ? ccr_pkg::BOOST_CURRENT_LIMIT_HIGH_MA
                                                      : ccr_pkg::BOOST_CURRENT_LIMIT_LOW_MA;              // R08
    next_high_res   = ~cur_lim[ccr_pkg::SWITCH_FULL_ON_BIT] && (in_lim_ma < ccr_pkg::SWITCH_THRESH_MA); // R09
  end

  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      WATCHDOG_KICK_O          <= 1'b0;
      LIGHT_LOAD_MODE_ENABLE_O <= 1'b0;
      REVERSE_BOOST_ACTIVE_O   <= 1'b0;
      CHARGE_ACTIVE_O          <= 1'b0;
      MIN_SYSTEM_MV_O          <= '0;
      MIN_BATTERY_SEL_O        <= 1'b0;
      BOOST_CURRENT_LIMIT_MA_O <= '0;
      INPUT_SWITCH_HIGH_RES_O  <= 1'b0;
    end else begin
      WATCHDOG_KICK_O          <= ctrl_one[ccr_pkg::WDOG_KICK_BIT]; // R03
      LIGHT_LOAD_MODE_ENABLE_O <= next_light_load;
      REVERSE_BOOST_ACTIVE_O   <= next_boost_act;
      CHARGE_ACTIVE_O          <= next_charge_act;
      MIN_SYSTEM_MV_O          <= next_min_sys_mv;
      MIN_BATTERY_SEL_O        <= ctrl_one[ccr_pkg::MIN_BAT_BIT];
      BOOST_CURRENT_LIMIT_MA_O <= next_boost_current_limit;
      INPUT_SWITCH_HIGH_RES_O  <= next_high_res;
    end
  end

  // Current code decode lives in its own module
  ccr_current_lut u_lut (
    .clk_i       (CLK_I),
    .rst_n_i     (RST_N_I),
    .fast_code_i (cur_lim[ccr_pkg::FAST_CODE_MSB:0]),
    .pre_code_i  (pre_term[ccr_pkg::PRE_CODE_MSB:ccr_pkg::PRE_CODE_LSB]),
    .term_code_i (pre_term[ccr_pkg::TERM_CODE_MSB:0]),
    .currents_o  (CURRENTS_O)
  );

endmodule // ccr_regs

// ---- rtl/ccr_pkg.sv ----
package ccr_pkg;

  // Register offsets on the byte-wide register port
  localparam logic [7:0] ADDR_CTRL_ONE     = 8'h01;
  localparam logic [7:0] ADDR_CURRENT_LIM  = 8'h02;
  localparam logic [7:0] ADDR_PRE_TERM     = 8'h03;

  // Reset values
  localparam logic [7:0] RST_CTRL_ONE      = 8'h1a;
  localparam logic [7:0] RST_CURRENT_LIM   = 8'hb4;
  localparam logic [7:0] RST_PRE_TERM      = 8'haa;

  // Bits restored by watchdog expiry (the rest only by register reset)
  localparam logic [7:0] WDOG_MASK_CTRL    = 8'h70;
  localparam logic [7:0] WDOG_MASK_CURLIM  = 8'hbf;
  localparam logic [7:0] WDOG_MASK_PRETERM = 8'hff;

  // Field positions, first control register
  localparam int LIGHT_LOAD_DIS_BIT = 7;
  localparam int WDOG_KICK_BIT      = 6;
  localparam int REV_BOOST_BIT      = 5;
  localparam int CHG_EN_BIT         = 4;
  localparam int MIN_SYS_MSB        = 3;
  localparam int MIN_SYS_LSB        = 1;
  localparam int MIN_BAT_BIT        = 0;

  // Field positions, current registers
  localparam int BOOST_CURRENT_LIMIT_BIT      = 7;
  localparam int SWITCH_FULL_ON_BIT = 6;
  localparam int FAST_CODE_MSB      = 5;
  localparam int PRE_CODE_MSB       = 7;
  localparam int PRE_CODE_LSB       = 4;
  localparam int TERM_CODE_MSB      = 3;

  // Analog setting values
  localparam logic [11:0] BOOST_CURRENT_LIMIT_LOW_MA  = 12'h1f4; // 500 mA
  localparam logic [11:0] BOOST_CURRENT_LIMIT_HIGH_MA = 12'h4b0; // 1200 mA
  localparam logic [11:0] IN_LIM_OFFSET_MA  = 12'h064; // 100 mA
  localparam logic [11:0] IN_LIM_STEP_MA    = 12'h064; // 100 mA per code
  localparam logic [11:0] SWITCH_THRESH_MA  = 12'h2bc; // 700 mA

  // Fast-charge table segments: first code, base mA, step mA
  localparam logic [5:0]  FC_SEG1_CODE = 6'h09;
  localparam logic [5:0]  FC_SEG2_CODE = 6'h10;
  localparam logic [5:0]  FC_SEG3_CODE = 6'h18;
  localparam logic [5:0]  FC_SEG4_CODE = 6'h20;
  localparam logic [5:0]  FC_SEG5_CODE = 6'h30;
  localparam logic [5:0]  FC_SAT_CODE  = 6'h3d;
  localparam logic [11:0] FC_SEG0_STEP = 12'h005;
  localparam logic [11:0] FC_SEG1_BASE = 12'h032;  // 50
  localparam logic [11:0] FC_SEG1_STEP = 12'h00a;
  localparam logic [11:0] FC_SEG2_BASE = 12'h082;  // 130
  localparam logic [11:0] FC_SEG2_STEP = 12'h014;
  localparam logic [11:0] FC_SEG3_BASE = 12'h12c;  // 300
  localparam logic [11:0] FC_SEG3_STEP = 12'h01e;
  localparam logic [11:0] FC_SEG4_BASE = 12'h21c;  // 540
  localparam logic [11:0] FC_SEG4_STEP = 12'h03c;
  localparam logic [11:0] FC_SEG5_BASE = 12'h5dc;  // 1500
  localparam logic [11:0] FC_SEG5_STEP = 12'h078;
  localparam logic [11:0] FC_SAT_MA    = 12'hbb8;  // 3000

  // Register access from the serial port engine
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } ccr_reg_req_t;

  // Decoded currents, all in mA
  typedef struct packed {
    logic [11:0] fast_ma;
    logic [11:0] pre_ma;
    logic [11:0] term_ma;
  } ccr_currents_t;

endpackage

// ---- rtl/ccr_current_lut.sv ----
`timescale 1ns/10ps
module ccr_current_lut (
  input  wire logic                   clk_i,
  input  wire logic                   rst_n_i,
  input  wire logic [5:0]             fast_code_i,
  input  wire logic [3:0]             pre_code_i,
  input  wire logic [3:0]             term_code_i,
  output ccr_pkg::ccr_currents_t      currents_o
);

  // Shared pre-charge / termination table, 5 mA at 0000 .. 240 mA at 1111
  localparam logic [11:0] SMALL_TABLE [16] = '{
    12'h005, 12'h00a, 12'h00f, 12'h014, 12'h01e, 12'h028, 12'h032, 12'h03c,
    12'h050, 12'h064, 12'h078, 12'h08c, 12'h0a0, 12'h0b4, 12'h0c8, 12'h0f0};

  ccr_pkg::ccr_currents_t next_currents;

  // Segmented fast-charge decode; arithmetic beats a 64-entry table in area
  function automatic logic [11:0] fast_ma(input logic [5:0] c);
    logic [11:0] cc;
    cc = {6'h00, c};
    if (c >= ccr_pkg::FC_SAT_CODE)
      fast_ma = ccr_pkg::FC_SAT_MA;                                                            // R10
    else if (c >= ccr_pkg::FC_SEG5_CODE)
      fast_ma = 12'(ccr_pkg::FC_SEG5_BASE + ccr_pkg::FC_SEG5_STEP * (cc - {6'h00, ccr_pkg::FC_SEG5_CODE}));
    else if (c >= ccr_pkg::FC_SEG4_CODE)
      fast_ma = 12'(ccr_pkg::FC_SEG4_BASE + ccr_pkg::FC_SEG4_STEP * (cc - {6'h00, ccr_pkg::FC_SEG4_CODE}));
    else if (c >= ccr_pkg::FC_SEG3_CODE)
      fast_ma = 12'(ccr_pkg::FC_SEG3_BASE + ccr_pkg::FC_SEG3_STEP * (cc - {6'h00, ccr_pkg::FC_SEG3_CODE}));
    else if (c >= ccr_pkg::FC_SEG2_CODE)
      fast_ma = 12'(ccr_pkg::FC_SEG2_BASE + ccr_pkg::FC_SEG2_STEP * (cc - {6'h00, ccr_pkg::FC_SEG2_CODE}));
    else if (c >= ccr_pkg::FC_SEG1_CODE)
      fast_ma = 12'(ccr_pkg::FC_SEG1_BASE + ccr_pkg::FC_SEG1_STEP * (cc - {6'h00, ccr_pkg::FC_SEG1_CODE}));
    else
      fast_ma = 12'(ccr_pkg::FC_SEG0_STEP * cc);
  endfunction

  // Decode all three codes
  always_comb begin
    next_currents.fast_ma = fast_ma(fast_code_i);   // R10
    next_currents.pre_ma  = SMALL_TABLE[pre_code_i];  // R12
    next_currents.term_ma = SMALL_TABLE[term_code_i]; // R13
  end

  // Registered so the top outputs come from flops
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      currents_o <= '0;
    end else begin
      currents_o <= next_currents;
    end
  end

endmodule // ccr_current_lut

// ---- testbench/ccr_host_model.sv ----
`timescale 1ns/10ps
module ccr_host_model (
  input  wire logic                   clk_i,
  output ccr_pkg::ccr_reg_req_t       req_o,
  input  wire logic [7:0]             rd_data_i,
  input  wire logic                   rd_valid_i
);
  // Idle port until the first access
  initial req_o = '0;

  // One-cycle write pulse, launched off the falling edge
  task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_i);
    req_o = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(negedge clk_i);
    req_o = '0;
  endtask

  // Answer stands one cycle only, so sample at the next falling edge
  task automatic read_reg(input logic [7:0] a, output logic [7:0] d, output logic v);
    @(negedge clk_i);
    req_o = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(negedge clk_i);
    req_o = '0;
    d = rd_data_i;
    v = rd_valid_i;
  endtask
endmodule // ccr_host_model

// ---- testbench/ccr_regs_monitor.sv ----
`timescale 1ns/10ps
module ccr_regs_monitor (
  input wire logic                   CLK_I,
  input wire logic                   RST_N_I,
  input wire ccr_pkg::ccr_reg_req_t  REQ_I,
  input wire logic                   REG_RESET_CMD_I,
  input wire logic                   WDOG_EXPIRED_I,
  input wire logic                   CHARGE_ENABLE_PIN_N_I,
  input wire logic [7:0]             RD_DATA_O,
  input wire logic                   RD_VALID_O,
  input wire logic                   WATCHDOG_KICK_O,
  input wire logic                   LIGHT_LOAD_MODE_ENABLE_O,
  input wire logic                   REVERSE_BOOST_ACTIVE_O,
  input wire logic                   CHARGE_ACTIVE_O,
  input wire logic [11:0]            MIN_SYSTEM_MV_O,
  input wire logic [11:0]            BOOST_CURRENT_LIMIT_MA_O,
  input wire ccr_pkg::ccr_currents_t CURRENTS_O
);
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (!RST_N_I);
  // Register reset command, then its decoded defaults
  sequence s_reset_cmd;
    REG_RESET_CMD_I && RST_N_I;
  endsequence
  sequence s_defaults_out;
    BOOST_CURRENT_LIMIT_MA_O == 12'h4b0 && MIN_SYSTEM_MV_O == 12'hdac && LIGHT_LOAD_MODE_ENABLE_O;
  endsequence
  a_read_answer_pulse: assert property (REQ_I.rd |=> RD_VALID_O) else $error("read not answered");
  a_quiet_read_port: assert property (!REQ_I.rd |=> !RD_VALID_O && RD_DATA_O == 8'h00)
    else $error("read port not quiet");
  a_boost_beats_charge: assert property (REVERSE_BOOST_ACTIVE_O |-> !CHARGE_ACTIVE_O)
    else $error("boost and charge");
  a_pin_blocks_charge: assert property (CHARGE_ENABLE_PIN_N_I [*3] |-> !CHARGE_ACTIVE_O)
    else $error("pin ignored");
  a_boost_limit_values: assert property ($past(RST_N_I) |-> BOOST_CURRENT_LIMIT_MA_O inside {12'h1f4, 12'h4b0})
    else $error("bad boost limit");
  a_min_sys_range: assert property ($past(RST_N_I) |-> MIN_SYSTEM_MV_O inside {[12'ha28:12'he74]})
    else $error("bad minimum voltage");
  a_kick_self_clear: assert property (WDOG_EXPIRED_I |-> ##2 !WATCHDOG_KICK_O) else $error("kick kept");
  a_reset_cmd_defaults: assert property (s_reset_cmd |-> ##2 s_defaults_out)
    else $error("defaults lost");
  a_reset_cmd_currents: assert property (s_reset_cmd |-> ##3 CURRENTS_O == {12'h7bc, 12'h078, 12'h078})
    else $error("current defaults lost");
endmodule // ccr_regs_monitor
bind ccr_regs ccr_regs_monitor u_mon (.CLK_I(CLK_I), .RST_N_I(RST_N_I), .REQ_I(REQ_I),
  .REG_RESET_CMD_I(REG_RESET_CMD_I), .WDOG_EXPIRED_I(WDOG_EXPIRED_I), .CHARGE_ENABLE_PIN_N_I(CHARGE_ENABLE_PIN_N_I),
  .RD_DATA_O(RD_DATA_O), .RD_VALID_O(RD_VALID_O), .WATCHDOG_KICK_O(WATCHDOG_KICK_O),
  .LIGHT_LOAD_MODE_ENABLE_O(LIGHT_LOAD_MODE_ENABLE_O), .REVERSE_BOOST_ACTIVE_O(REVERSE_BOOST_ACTIVE_O),
  .CHARGE_ACTIVE_O(CHARGE_ACTIVE_O), .MIN_SYSTEM_MV_O(MIN_SYSTEM_MV_O),
  .BOOST_CURRENT_LIMIT_MA_O(BOOST_CURRENT_LIMIT_MA_O), .CURRENTS_O(CURRENTS_O));

// ---- testbench/tb_charger_control_current_regs.sv ----
`timescale 1ns/10ps
module tb_charger_control_current_regs;
  logic clk = 1'b0, rst_n = 1'b0, rcmd = 1'b0, wexp = 1'b0, wres = 1'b0, pin_n = 1'b0;
  logic [4:0] ilim = 5'h17;
  ccr_pkg::ccr_reg_req_t req;
  logic [7:0] rdata;
  logic rvalid, kick, llm, boost, chg, mbat, hres;
  logic [11:0] msys, blim;
  ccr_pkg::ccr_currents_t cur;
  int num_errors = 0, checks_done = 0;
  logic [11:0] small_tab [16] = '{5, 10, 15, 20, 30, 40, 50, 60, 80, 100, 120, 140, 160, 180, 200, 240};
  logic [11:0] sys_tab [8] = '{2600, 2800, 3000, 3200, 3400, 3500, 3600, 3700};
  // 4 ns period clock
  always #2 clk = ~clk;
  ccr_host_model host (.clk_i(clk), .req_o(req), .rd_data_i(rdata), .rd_valid_i(rvalid));
  ccr_regs uut (.CLK_I(clk), .RST_N_I(rst_n), .REQ_I(req), .REG_RESET_CMD_I(rcmd), .WDOG_EXPIRED_I(wexp),
    .WDOG_RESTARTED_I(wres), .CHARGE_ENABLE_PIN_N_I(pin_n), .INPUT_CURRENT_LIMIT_I(ilim), .RD_DATA_O(rdata),
    .RD_VALID_O(rvalid), .WATCHDOG_KICK_O(kick), .LIGHT_LOAD_MODE_ENABLE_O(llm), .REVERSE_BOOST_ACTIVE_O(boost),
    .CHARGE_ACTIVE_O(chg), .MIN_SYSTEM_MV_O(msys), .MIN_BATTERY_SEL_O(mbat), .BOOST_CURRENT_LIMIT_MA_O(blim),
    .INPUT_SWITCH_HIGH_RES_O(hres), .CURRENTS_O(cur));
  // Segmented fast-charge table, saturating at the top
  function automatic logic [11:0] fc_ma(input int c);
    if (c <= 8) return 12'(5 * c);
    if (c < 16) return 12'(50 + 10 * (c - 9));
    if (c < 24) return 12'(130 + 20 * (c - 16));
    if (c < 32) return 12'(300 + 30 * (c - 24));
    if (c < 48) return 12'(540 + 60 * (c - 32));
    if (c < 61) return 12'(1500 + 120 * (c - 48));
    return 12'(3000);
  endfunction
  task automatic chk(input string n, input logic [11:0] e, input logic [11:0] g);
    checks_done++;
    if (g !== e) begin
      num_errors++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    logic v;
    host.read_reg(a, d, v);
    chk("rd_valid", 12'h001, {11'h000, v});
    chk("rd_data", {4'h0, e}, {4'h0, d});
  endtask
  // Writes and command pulses leave the decoded outputs three cycles to settle
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    host.write_reg(a, d);
    repeat (3) @(negedge clk);
  endtask
  task automatic pulse(input int k);
    @(negedge clk);
    {rcmd, wexp, wres} = 3'b100 >> k;
    @(negedge clk);
    {rcmd, wexp, wres} = 3'b000;
    repeat (3) @(negedge clk);
  endtask
  task automatic print_verdict();
    if (num_errors == 0 && checks_done > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // Hang guard, far beyond the some 550 cycles of the sequence
  initial begin
    #100000;
    num_errors++;
    print_verdict();
  end
  initial begin
    repeat (12) @(negedge clk);
    rst_n = 1'b1;
    repeat (2) @(negedge clk);
    rd(8'h01, 8'h1a);
    rd(8'h02, 8'hb4);
    rd(8'h03, 8'haa);
    chk("llm", 12'h001, {11'h000, llm});
    chk("charge", 12'h001, {11'h000, chg});
    chk("sys", 12'd3500, msys);
    chk("blim", 12'd1200, blim);
    chk("hres", 12'h000, {11'h000, hres});
    wr(8'h04, 8'h55);
    rd(8'h04, 8'h00);
    for (int c = 0; c < 64; c++) begin
      wr(8'h02, 8'(c));
      chk("fast", fc_ma(c), cur.fast_ma);
      chk("blim0", 12'd500, blim);
    end
    for (int c = 0; c < 16; c++) begin
      wr(8'h03, {4'(c), 4'(15 - c)});
      chk("pre", small_tab[c], cur.pre_ma);
      chk("term", small_tab[15 - c], cur.term_ma);
    end
    for (int c = 0; c < 8; c++) begin
      wr(8'h01, {4'h1, 3'(c), 1'b1});
      chk("sys", sys_tab[c], msys);
      rd(8'h01, {4'h1, 3'(c), 1'b1});
      chk("mbat", 12'h001, {11'h000, mbat});
    end
    ilim = 5'h05;
    wr(8'h02, 8'h00);
    chk("hres600", 12'h001, {11'h000, hres});
    ilim = 5'h06;
    repeat (3) @(negedge clk);
    chk("hres700", 12'h000, {11'h000, hres});
    wr(8'h01, 8'h30);
    chk("boost", 12'h001, {11'h000, boost});
    chk("chg_boost", 12'h000, {11'h000, chg});
    wr(8'h01, 8'h10);
    pin_n = 1'b1;
    repeat (3) @(negedge clk);
    chk("chg_pin", 12'h000, {11'h000, chg});
    pin_n = 1'b0;
    wr(8'h01, 8'h40);
    chk("kick", 12'h001, {11'h000, kick});
    rd(8'h01, 8'h40);
    pulse(2);
    chk("kick_clr", 12'h000, {11'h000, kick});
    rd(8'h01, 8'h00);
    wr(8'h01, 8'he2);
    wr(8'h02, 8'h40);
    wr(8'h03, 8'h00);
    pulse(1);
    rd(8'h01, 8'h92);
    rd(8'h02, 8'hf4);
    rd(8'h03, 8'haa);
    chk("llm_off", 12'h000, {11'h000, llm});
    pulse(0);
    rd(8'h01, 8'h1a);
    rd(8'h02, 8'hb4);
    print_verdict();
  end
endmodule // tb_charger_control_current_regs
